// file: design/dmch_handler.sv
// dmch_handler: command interpreter for commands 0 to 7 of the display module
`timescale 1ns/100ps
module dmch_handler
  import dmch_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_CYC,
  parameter int QUIET_CYCLES = QUIET_CYC,
  parameter int PULSE_UNIT   = PULSE_UNIT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  output logic             rx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  pulse_len,
  output logic             host_reset_q,
  output logic             host_power_q,
  output logic             self_restart_q,
  output logic             busy_q,
  output logic             save_boot_q,
  output logic [4:0]       cursor_col_q,
  output logic             cursor_row_q
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [6:0] {
    DMCH_S_RECV  = 7'h01,
    DMCH_S_EXEC  = 7'h02,
    DMCH_S_CLEAR = 7'h04,
    DMCH_S_SEND  = 7'h08,
    DMCH_S_CRC   = 7'h10,
    DMCH_S_HOST  = 7'h20,
    DMCH_S_QUIET = 7'h40
  } dmch_state_t;

  dmch_state_t      st_q;
  logic [7:0]       pkt_q [MAX_PAY+2];
  logic [4:0]       rx_cnt_q;
  logic             rx_over_q;
  logic [7:0]       user_q [LINE_BYTES];
  logic [7:0]       disp_q [2*ROW_COLS];
  logic [7:0]       boot_disp_q [2*ROW_COLS];
  logic [5:0]       boot_cur_q;
  logic [7:0]       boot_pulse_q;
  logic [5:0]       clr_q;
  logic [1:0]       ans_kind_q;
  logic [4:0]       ans_len_q;
  logic [1:0]       ans_src_q;
  logic [4:0]       tx_idx_q;
  logic [1:0]       crc_idx_q;
  logic [15:0]      crc_q;
  logic [1:0]       restart_kind_q;
  logic [31:0]      timer_q;
  logic [7:0]       fifo_din;
  logic             fifo_push;
  logic             fifo_ready;
  logic [7:0]       pay_byte;
  logic [7:0]       tx_byte;
  logic [5:0]       cmd;
  logic [4:0]       len;
  logic [23:0]      pat;
  logic             cmd_ok;
  logic             rx_take;

  assign cmd     = pkt_q[0][5:0];
  assign len     = pkt_q[1][4:0];
  assign pat     = {pkt_q[2], pkt_q[3], pkt_q[4]};
  assign rx_take = rx_valid && rx_ready;

  // frames are only taken while idle; a restart hold shows as no ready
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_ready <= 1'b0;
    else
      rx_ready <= (st_q == DMCH_S_RECV) && !(rx_take && rx_last);
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC-16 step, reflected polynomial, one byte at a time
  function automatic logic [15:0] dmch_crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
    return r;
  endfunction : dmch_crc_step

  // command shape check; anything else is an error answer
  always_comb
  begin
    cmd_ok = 1'b0;
    if (pkt_q[0][7:6] == 2'b00 && !rx_over_q && rx_cnt_q == 5'(len + 5'd2))
    begin
      case (cmd)
        CMD_ECHO:      cmd_ok = (len <= 5'(MAX_PAY));
        CMD_VERSION:   cmd_ok = (len == 5'd0);
        CMD_USER_WR:   cmd_ok = (len == 5'(LINE_BYTES));
        CMD_USER_RD:   cmd_ok = (len == 5'd0);
        CMD_SAVE_BOOT: cmd_ok = (len == 5'd0);
        CMD_RESTART:   cmd_ok = (pkt_q[1] == LEN_RESTART) &&
                                (pat == PAT_SELF || pat == PAT_HOST_RST ||
                                 pat == PAT_HOST_PWR);
        CMD_CLEAR:     cmd_ok = (len == 5'd0);
        CMD_TOP_LINE:  cmd_ok = (len == 5'(LINE_BYTES));
        default:       cmd_ok = 1'b0;
      endcase
    end
  end

  // answer payload byte by source: echo, version text, user area
  always_comb
  begin
    case (ans_src_q)
      2'd1:    pay_byte = VERSION_TEXT[8*(15-4'(tx_idx_q - 5'd2)) +: 8];
      2'd2:    pay_byte = user_q[4'(tx_idx_q - 5'd2)];
      default: pay_byte = pkt_q[tx_idx_q];
    endcase
    if (tx_idx_q == 5'd0)
      tx_byte = {ans_kind_q, cmd};
    else if (tx_idx_q == 5'd1)
      tx_byte = {3'b000, ans_len_q};
    else
      tx_byte = pay_byte;
    fifo_push = 1'b0;
    fifo_din  = tx_byte;
    if (st_q == DMCH_S_SEND)
      fifo_push = 1'b1;
    else if (st_q == DMCH_S_CRC)
    begin
      fifo_push = 1'b1;
      fifo_din  = crc_idx_q[0] ? crc_q[15:8] : crc_q[7:0];
    end
  end

  // for source 1/2 pay_byte indexes payload from zero
  ////////////////////////////////////////////////////////////////////////////
  // main sequencer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q           <= DMCH_S_RECV;
      rx_cnt_q       <= '0;
      rx_over_q      <= 1'b0;
      clr_q          <= '0;
      ans_kind_q     <= KIND_RESP;
      ans_len_q      <= '0;
      ans_src_q      <= '0;
      tx_idx_q       <= '0;
      crc_idx_q      <= '0;
      crc_q          <= CRC_INIT;
      restart_kind_q <= '0;
      timer_q        <= '0;
      host_reset_q   <= 1'b0;
      host_power_q   <= 1'b0;
      self_restart_q <= 1'b0;
      busy_q         <= 1'b0;
      save_boot_q    <= 1'b0;
      cursor_col_q   <= '0;
      cursor_row_q   <= 1'b0;
      boot_cur_q     <= '0;
      boot_pulse_q   <= PULSE_LEN_RST;
    end
    else
    begin
      save_boot_q    <= 1'b0;
      self_restart_q <= 1'b0;
      case (st_q)
        DMCH_S_RECV:
        begin
          busy_q <= 1'b0;
          if (rx_take)
          begin
            if (rx_cnt_q == 5'(MAX_PAY + 2))
              rx_over_q <= 1'b1;
            else
              rx_cnt_q <= 5'(rx_cnt_q + 5'd1);
            if (rx_last)
            begin
              st_q   <= DMCH_S_EXEC;
              busy_q <= 1'b1;
            end
          end
        end
        DMCH_S_EXEC:
        begin
          ans_kind_q <= cmd_ok ? KIND_RESP : KIND_ERR;
          ans_len_q  <= '0;
          ans_src_q  <= 2'd0;
          tx_idx_q   <= '0;
          crc_q      <= CRC_INIT;
          st_q       <= DMCH_S_SEND;
          if (cmd_ok)
          begin
            case (cmd)
              CMD_ECHO:    ans_len_q <= len;
              CMD_VERSION:
              begin
                ans_len_q <= 5'(LINE_BYTES);
                ans_src_q <= 2'd1;
              end
              CMD_USER_RD:
              begin
                ans_len_q <= 5'(LINE_BYTES);
                ans_src_q <= 2'd2;
              end
              CMD_SAVE_BOOT:
              begin
                save_boot_q  <= 1'b1;
                boot_cur_q   <= {cursor_row_q, cursor_col_q};
                boot_pulse_q <= pulse_len;
              end
              CMD_RESTART:
                restart_kind_q <= (pat == PAT_SELF)     ? 2'd1 :
                                  (pat == PAT_HOST_RST) ? 2'd2 : 2'd3;
              CMD_CLEAR:
              begin
                clr_q <= '0;
                st_q  <= DMCH_S_CLEAR;
              end
              default: ;
            endcase
          end
        end
        DMCH_S_CLEAR:
        begin
          clr_q <= 6'(clr_q + 6'd1);
          if (clr_q == 6'(2*ROW_COLS - 1))
          begin
            cursor_col_q <= '0;
            cursor_row_q <= 1'b0;
            st_q         <= DMCH_S_SEND;
          end
        end
        DMCH_S_SEND:
        begin
          if (fifo_ready)                                             // stall on back-pressure
          begin
            crc_q    <= dmch_crc_step(crc_q, fifo_din);
            tx_idx_q <= 5'(tx_idx_q + 5'd1);
            if (tx_idx_q == 5'(ans_len_q + 5'd1))
            begin
              crc_idx_q <= '0;
              st_q      <= DMCH_S_CRC;
            end
          end
        end
        DMCH_S_CRC:
        begin
          if (fifo_ready)
          begin
            crc_idx_q <= 2'(crc_idx_q + 2'd1);
            if (crc_idx_q == 2'd1)
            begin
              timer_q <= '0;
              st_q    <= (restart_kind_q != 2'd0) ? DMCH_S_HOST : DMCH_S_RECV;
              rx_cnt_q  <= '0;
              rx_over_q <= 1'b0;
            end
          end
        end
        DMCH_S_HOST:
        begin
          timer_q      <= timer_q + 32'd1;
          host_reset_q <= (restart_kind_q == 2'd2);
          host_power_q <= (restart_kind_q == 2'd3);
          if ((restart_kind_q == 2'd1) ||
              (restart_kind_q == 2'd2 && timer_q >= 32'(RESET_CYCLES)) ||
              (restart_kind_q == 2'd3 &&
               timer_q >= 32'(boot_pulse_q) * 32'(PULSE_UNIT)))
          begin
            host_reset_q   <= 1'b0;
            host_power_q   <= 1'b0;
            self_restart_q <= 1'b1;
            restart_kind_q <= '0;
            timer_q        <= '0;
            cursor_col_q   <= boot_cur_q[4:0];
            cursor_row_q   <= boot_cur_q[5];
            st_q           <= DMCH_S_QUIET;
          end
        end
        DMCH_S_QUIET:
        begin
          timer_q <= timer_q + 32'd1;
          if (timer_q >= 32'(QUIET_CYCLES - 1))
            st_q <= DMCH_S_RECV;
        end
        default: st_q <= DMCH_S_RECV;
      endcase
    end
  end

  // packet capture; no reset needed on storage
  always_ff @(posedge sys_clk)
  begin
    if (rx_take && !rx_over_q && rx_cnt_q < 5'(MAX_PAY + 2))
      pkt_q[rx_cnt_q] <= rx_data;
  end

  // user area write; kept across soft restarts like flash would be
  always_ff @(posedge sys_clk)
  begin
    if (st_q == DMCH_S_EXEC && cmd_ok && cmd == CMD_USER_WR)
      for (int i = 0; i < LINE_BYTES; i++)
        user_q[i] <= pkt_q[i+2];
  end

  // character memory: clear, top-line write, boot copy and restore
  always_ff @(posedge sys_clk)
  begin
    if (st_q == DMCH_S_CLEAR)
      disp_q[clr_q] <= SPACE_CHAR;
    else if (st_q == DMCH_S_EXEC && cmd_ok && cmd == CMD_TOP_LINE)
      for (int i = 0; i < LINE_BYTES; i++)
        disp_q[CENTRE_COL + i] <= pkt_q[i+2];
    else if (self_restart_q)
      for (int i = 0; i < 2*ROW_COLS; i++)
        disp_q[i] <= boot_disp_q[i];
    if (save_boot_q)
      for (int i = 0; i < 2*ROW_COLS; i++)
        boot_disp_q[i] <= disp_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer path buffering
  dmch_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   (fifo_din),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  chk_err_kind: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == DMCH_S_EXEC && !cmd_ok) |=> ans_kind_q == KIND_ERR && ans_len_q == 5'd0)
    else $error("bad command not answered as error");
  chk_echo_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == DMCH_S_EXEC && cmd_ok && cmd == CMD_ECHO) |=> ans_len_q == $past(len))
    else $error("echo length differs");
  chk_ver_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == DMCH_S_EXEC && cmd_ok && cmd == CMD_VERSION) |=> ans_len_q == 5'd16)
    else $error("version answer not 16 bytes");
  chk_save_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    save_boot_q |-> $past(st_q == DMCH_S_EXEC && cmd == CMD_SAVE_BOOT))
    else $error("save without command");
  chk_restart_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == DMCH_S_HOST) |-> ans_kind_q == KIND_RESP && cmd == CMD_RESTART)
    else $error("restart without ack");
  chk_quiet_rx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == DMCH_S_QUIET) |=> !rx_ready)
    else $error("commands taken during quiet time");
  chk_clear_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == DMCH_S_EXEC && cmd_ok && cmd == CMD_CLEAR) |=> st_q == DMCH_S_CLEAR &&
    clr_q == 6'd0 ##39 st_q == DMCH_S_CLEAR && clr_q == 6'd39 ##1
    st_q == DMCH_S_SEND && cursor_col_q == 5'd0)
    else $error("clear sequence wrong");
  chk_host_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(host_reset_q && host_power_q))
    else $error("reset and power both driven");
endmodule : dmch_handler

// file: design/dmch_pkg.sv
// dmch_pkg: constants shared by the display module command handler
// Function
// - echo type 0x00, 0..16 bytes, returned unchanged with type 0x40
// - version query type 0x01 answers 0x41 with 16-byte text
// - sixteen-byte nonvolatile user area; write must carry exactly 16 bytes
// - user-area read returns the stored sixteen bytes
// - save-boot command 0x04 copies live settings to boot store, answers 0x44
// - reporting enables, fan fail-safe and watchdog are never saved
// - restart pattern 8,18,99: acknowledge, then restart self
// - after a restart commands may be ignored up to 3 seconds
// - pattern 12,28,97: acknowledge, drive host reset ~1.5 s, then restart
// - pattern 3,11,95: acknowledge, pulse host power for set length, restart
// - every accepted restart variant acknowledges with 0x45, empty payload
// - clear screen 0x06 fills memory with 0x20, cursor home, answers 0x46
// - top-line write 0x07 takes 16 bytes into centre top row, answers 0x47
// - packet is type, length, payload, then 16-bit CRC sent low byte first; only answers carry it, received packets end at the payload
// - answer type keeps low six bits; top bits 01 response, 11 error
// - every packet answered within 250 ms
package dmch_pkg;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          ANSWER_MS      = 250;
  localparam int          ANSWER_CYC     = CLK_HZ / 1000 * ANSWER_MS;
  localparam int          RESET_MS       = 1500;
  localparam int          RESET_CYC      = CLK_HZ / 1000 * RESET_MS;
  localparam int          QUIET_MS       = 3000;
  localparam int          QUIET_CYC      = CLK_HZ / 1000 * QUIET_MS;
  localparam int          PULSE_UNIT_MS  = 32;
  localparam int          PULSE_UNIT_CYC = CLK_HZ / 1000 * PULSE_UNIT_MS;
  localparam logic [7:0]  PULSE_LEN_RST  = 8'h10;
  localparam int          MAX_PAY        = 16;
  localparam int          LINE_BYTES     = 16;
  localparam int          ROW_COLS       = 20;
  localparam int          CENTRE_COL     = 2;
  localparam logic [7:0]  SPACE_CHAR     = 8'h20;
  localparam logic [1:0]  KIND_RESP      = 2'h1;
  localparam logic [1:0]  KIND_ERR       = 2'h3;
  localparam logic [5:0]  CMD_ECHO       = 6'h00;
  localparam logic [5:0]  CMD_VERSION    = 6'h01;
  localparam logic [5:0]  CMD_USER_WR    = 6'h02;
  localparam logic [5:0]  CMD_USER_RD    = 6'h03;
  localparam logic [5:0]  CMD_SAVE_BOOT  = 6'h04;
  localparam logic [5:0]  CMD_RESTART    = 6'h05;
  localparam logic [5:0]  CMD_CLEAR      = 6'h06;
  localparam logic [5:0]  CMD_TOP_LINE   = 6'h07;
  localparam logic [23:0] PAT_SELF       = 24'h081263;
  localparam logic [23:0] PAT_HOST_RST   = 24'h0C1C61;
  localparam logic [23:0] PAT_HOST_PWR   = 24'h030B5F;
  localparam logic [7:0]  LEN_RESTART    = 8'h03;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REV   = 16'h8408;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          FIFO_WIDTH     = 8;
  // version text: arbitrary neutral identity string
  localparam logic [127:0] VERSION_TEXT  = 128'h444D4348_3A68312E_302C7631_2E303030;
endpackage : dmch_pkg

// file: design/dmch_fifo.sv
// dmch_fifo: small valid/ready FIFO on the answer byte path
`timescale 1ns/100ps
module dmch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // honest flags straight from the count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset; only the pointers and count need a defined start
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= AW'(wr_q + 1'b1);
      if (pop)
        rd_q <= AW'(rd_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule : dmch_fifo

// file: bench/dmch_host_model.sv
// dmch_host_model: host side that drains answer bytes and stalls on demand
`timescale 1ns/100ps
module dmch_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       stall
);
  logic [7:0] got[$];

  initial tx_ready = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // a byte is taken only at an edge where valid and ready meet; stall lets the
  // bench hold the answer path back so the buffer fills and must refuse
  always @(posedge sys_clk)
  begin
    if (rst_n && tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= #1 rst_n && !stall;
  end
endmodule : dmch_host_model

// file: bench/tb_display_module_command_handler.sv
// tb_display_module_command_handler: self-checking bench for the command handler
`timescale 1ns/100ps
module tb_display_module_command_handler import dmch_pkg::*;;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic       rx_valid = 1'b0;
  logic       rx_last = 1'b0;
  logic       stall   = 1'b0;
  logic [7:0] pulse_len = 8'h03;
  logic       rx_ready, tx_valid, tx_ready, host_reset_q, host_power_q;
  logic       self_restart_q, busy_q, save_boot_q, cursor_row_q;
  logic [7:0] tx_data;
  logic [4:0] cursor_col_q;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cyc = 0, n_rst = 0, n_pwr = 0, n_self = 0, n_save = 0;
  logic [7:0] pq[$];

  // short counts keep the restart scenarios brief
  dmch_handler #(.RESET_CYCLES(20), .QUIET_CYCLES(30), .PULSE_UNIT(4)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .pulse_len(pulse_len), .host_reset_q(host_reset_q),
    .host_power_q(host_power_q), .self_restart_q(self_restart_q), .busy_q(busy_q),
    .save_boot_q(save_boot_q), .cursor_col_q(cursor_col_q), .cursor_row_q(cursor_row_q));

  dmch_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall));

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // pulse and level counters; a hang is cut short by the cycle ceiling
  always @(posedge sys_clk)
  begin
    cyc    += 1;
    n_rst  += int'(host_reset_q);
    n_pwr  += int'(host_power_q);
    n_self += int'(self_restart_q);
    n_save += int'(save_boot_q);
    if (cyc == 10000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // reflected crc as the answer carries it, worked out independently here
  function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i])
    begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
    end
    return c;
  endfunction : crc_of

  task automatic fill(input int n, input logic [7:0] base);
    pq.delete();
    for (int i = 0; i < n; i++)
      pq.push_back(base + 8'(i));
  endtask : fill

  // one packet of type, length and pq; each byte held until rx_ready was high
  task automatic send(input logic [7:0] ty);
    logic [7:0] b[$];
    b = {ty, 8'(pq.size()), pq};
    foreach (b[i])
    begin
      rx_data  <= b[i];
      rx_valid <= 1'b1;
      rx_last  <= (i == b.size() - 1);
      while (rx_ready !== 1'b1) @(posedge sys_clk) #1;
      @(posedge sys_clk) #1;
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~rx_data; // released line never shows the last byte
  endtask : send

  // answer must be type, length, pq, crc low byte first, and nothing more
  task automatic expect_ans(input logic [7:0] ty);
    logic [7:0]  e[$];
    logic [15:0] c;
    int          n;
    e = {ty, 8'(pq.size()), pq};
    c = crc_of(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    n = 0;
    while (host.got.size() < e.size() && n < 400)
    begin
      @(posedge sys_clk) #1;
      n++;
    end
    repeat (4) @(posedge sys_clk) #1;
    chk("answer_len", 8'(e.size()), 8'(host.got.size()));
    foreach (e[i])
      chk("answer_byte", e[i], host.got[i]);
    host.got.delete();
  endtask : expect_ans

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_echo();
    pq.delete();
    send(8'h00);
    expect_ans(8'h40);
    fill(16, 8'hF0);
    send(8'h00);
    expect_ans(8'h40);
    fill(17, 8'h11);
    send(8'h00);
    pq.delete();
    expect_ans(8'hC0);
  endtask : t_echo

  // answer longer than the buffer: it fills, refuses, then drains intact
  task automatic t_version();
    stall = 1'b1;
    pq.delete();
    send(8'h01);
    repeat (60) @(posedge sys_clk) #1;
    chk("tx_valid_held", 8'h01, {7'h00, tx_valid});
    chk("busy_held", 8'h01, {7'h00, busy_q});
    stall = 1'b0;
    for (int i = 0; i < 16; i++)
      pq.push_back(VERSION_TEXT[127 - 8 * i -: 8]);
    expect_ans(8'h41);
  endtask : t_version

  task automatic t_user();
    fill(16, 8'hA0);
    send(8'h02);
    pq.delete();
    expect_ans(8'h42);
    fill(15, 8'h50);
    send(8'h02);
    pq.delete();
    expect_ans(8'hC2);
    send(8'h03);
    fill(16, 8'hA0);
    expect_ans(8'h43);
  endtask : t_user

  task automatic t_save();
    int s;
    s = n_save;
    pq.delete();
    send(8'h04);
    expect_ans(8'h44);
    pq = {8'h01};
    send(8'h04);
    pq.delete();
    expect_ans(8'hC4);
    chk("save_pulses", 8'h01, 8'(n_save - s));
  endtask : t_save

  task automatic t_screen();
    fill(16, 8'h30);
    send(8'h07);
    pq.delete();
    expect_ans(8'h47);
    fill(15, 8'h30);
    send(8'h07);
    pq.delete();
    expect_ans(8'hC7);
    send(8'h06);
    expect_ans(8'h46);
    chk("cursor_col", 8'h00, {3'h0, cursor_col_q});
    chk("cursor_row", 8'h00, {7'h00, cursor_row_q});
  endtask : t_screen

  // host waits out the quiet time before sending again
  task automatic t_restart(input logic [23:0] pat, input logic [7:0] ack,
                           input int rx, input int px, input int sx);
    int r, p, s, n;
    r = n_rst;
    p = n_pwr;
    s = n_self;
    pq = {pat[23:16], pat[15:8], pat[7:0]};
    send(8'h05);
    pq.delete();
    expect_ans(ack);
    n = 0;
    while (rx_ready !== 1'b1 && n < 500)
    begin
      @(posedge sys_clk) #1;
      n++;
    end
    chk("host_reset_cycles", 8'(rx), 8'(n_rst - r));
    chk("host_power_cycles", 8'(px), 8'(n_pwr - p));
    chk("self_restarts", 8'(sx), 8'(n_self - s));
  endtask : t_restart

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk) #1;
    t_echo();
    t_version();
    t_user();
    t_save();
    t_screen();
    t_restart(PAT_SELF, 8'h45, 0, 0, 1);
    t_restart(PAT_HOST_RST, 8'h45, 20, 0, 1);
    t_restart(PAT_HOST_PWR, 8'h45, 0, 12, 1);
    t_restart(24'h081264, 8'hC5, 0, 0, 0);
    print_verdict();
  end
endmodule : tb_display_module_command_handler
